// >>> logic/tcm_pkg.sv
// Purpose: Shared constants and types of the timer compare block.
// Assumes: 32-bit AXI4-Lite register bus, byte offsets.
// Notes: All reset values of the block are zero, except the active-low pin enables (oe_n), which reset to one.
package tcm_pkg;
  // ==========================================================
  // Register map
  localparam int         AXI_AW     = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_CMPA   = 8'h08;
  localparam logic [7:0] OFF_CMPB   = 8'h0c;
  localparam logic [7:0] OFF_CAPTOP = 8'h10;
  localparam logic [7:0] OFF_FLAGS  = 8'h14;
  localparam logic [7:0] OFF_FORCE  = 8'h18;
  localparam logic [7:0] OFF_PIN    = 8'h1c;
  // ==========================================================
  // Field positions
  localparam int CTRL_WGM_LSB  = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_CS_LSB   = 8;
  localparam int FLG_OVF       = 0;
  localparam int FLG_CMPA      = 1;
  localparam int FLG_CMPB      = 2;
  localparam int FLG_CAP       = 3;
  localparam int PIN_DDRA      = 0;
  localparam int PIN_DDRB      = 1;
  localparam int PIN_PORTA     = 2;
  localparam int PIN_PORTB     = 3;
  localparam int FRC_A         = 0;
  localparam int FRC_B         = 1;
  // ==========================================================
  // Values
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [3:0]  WGM_NORMAL  = 4'h0;
  localparam logic [3:0]  WGM_CTC_A   = 4'h4;
  localparam logic [3:0]  WGM_CTC_CAP = 4'hc;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // ==========================================================
  // Prescaler divide factors as powers of two
  localparam int PS_W       = 10;
  localparam int PS_LOG8    = 3;
  localparam int PS_LOG16   = 4;
  localparam int PS_LOG32   = 5;
  localparam int PS_LOG64   = 6;
  localparam int PS_LOG256  = 8;
  localparam int PS_LOG1024 = 10;
  typedef enum logic [1:0] {
    COM_OFF = 2'b00, COM_TOGGLE = 2'b01, COM_CLEAR = 2'b10, COM_SET = 2'b11
  } tcm_com_t;
  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_DIV16 = 3'b110, CS_DIV32 = 3'b111
  } tcm_cs_t;
  typedef struct packed {
    tcm_com_t mode;
    logic     ddr;
    logic     port;
  } tcm_cou_cfg_t;
endpackage : tcm_pkg

// >>> logic/tcm_presc.sv
// Purpose: Timer prescaler giving one tick per selected division.
// Assumes: Runs on the system clock.
// Notes: EXTRA enables the divide-by-16 and divide-by-32 choices.
`timescale 1ns/100ps
module tcm_presc
  import tcm_pkg::*;
#(
  parameter int EXTRA = 1
) (
  input  wire logic    clk,
  input  wire logic    rst_n,
  input  wire logic    ce,
  input  wire tcm_cs_t cs,
  output logic         tick
);
  if (EXTRA < 0 || EXTRA > 1) begin : g_chk
    $error("EXTRA must be 0 or 1");
  end
  typedef struct packed {
    logic [PS_W-1:0] cnt;
    logic            tick;
  } tcm_ps_t;
  tcm_ps_t s;
  tcm_ps_t n;
  // ==========================================================
  // Divider
  always_comb begin
    n = s;
    n.cnt = s.cnt + 10'h001;
    unique case (cs)
      CS_STOP:    n.tick = 1'b0;
      CS_DIV1:    n.tick = 1'b1;
      CS_DIV8:    n.tick = &s.cnt[PS_LOG8-1:0];
      CS_DIV64:   n.tick = &s.cnt[PS_LOG64-1:0];
      CS_DIV256:  n.tick = &s.cnt[PS_LOG256-1:0];
      CS_DIV1024: n.tick = &s.cnt[PS_LOG1024-1:0];
      CS_DIV16:   n.tick = (EXTRA == 1) && (&s.cnt[PS_LOG16-1:0]);
      CS_DIV32:   n.tick = (EXTRA == 1) && (&s.cnt[PS_LOG32-1:0]);
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end
  assign tick = s.tick;
  chk_div8_phase: assert property (@(posedge clk) disable iff (!rst_n)
    ce && cs == CS_DIV8 && $past(cs) == CS_DIV8 && $past(ce) && tick |-> s.cnt[2:0] == 3'h0)
    else $error("divide-by-8 tick out of phase");
endmodule : tcm_presc

// >>> logic/tcm_cou.sv
// Purpose: One compare output channel: state register and pin override.
// Assumes: Match and force arrive as one-cycle pulses.
// Notes: Pin level and enable are registered copies of the next state.
`timescale 1ns/100ps
module tcm_cou
  import tcm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire tcm_cou_cfg_t cfg,
  input  wire logic         match,
  input  wire logic         force_go,
  output logic              pin,
  output logic              pin_oe_n,
  output logic              state
);
  typedef struct packed {
    logic state;
    logic pin;
    logic oe_n;
  } tcm_cou_t;
  tcm_cou_t s;
  tcm_cou_t n;
  logic     act;
  // ==========================================================
  // Output state and pin source
  always_comb begin
    n = s;
    act = match || force_go;
    if (act) begin
      unique case (cfg.mode)
        COM_OFF:    n.state = s.state;
        COM_TOGGLE: n.state = !s.state;
        COM_CLEAR:  n.state = 1'b0;
        COM_SET:    n.state = 1'b1;
      endcase
    end
    n.pin = (cfg.mode != COM_OFF) ? n.state : cfg.port;
    n.oe_n = !cfg.ddr;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.oe_n <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end
  assign pin = s.pin;
  assign pin_oe_n = s.oe_n;
  assign state = s.state;
  chk_state_reset: assert property (@(posedge clk) !rst_n |=> !s.state)
    else $error("state not cleared by reset");
  chk_mode_off_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ce && cfg.mode == COM_OFF |=> s.state == $past(s.state))
    else $error("state changed with mode off");
  chk_toggle_act: assert property (@(posedge clk) disable iff (!rst_n)
    ce && act && cfg.mode == COM_TOGGLE |=> s.state != $past(s.state))
    else $error("toggle did not toggle");
  chk_clear_set: assert property (@(posedge clk) disable iff (!rst_n)
    ce && act && cfg.mode[1] |=> s.state == $past(cfg.mode[0]))
    else $error("clear or set wrong");
  chk_pin_source: assert property (@(posedge clk) disable iff (!rst_n)
    ce && cfg.mode != COM_OFF |=> s.pin == s.state)
    else $error("pin not overridden");
  chk_pin_port: assert property (@(posedge clk) disable iff (!rst_n)
    ce && cfg.mode == COM_OFF |=> s.pin == $past(cfg.port))
    else $error("pin not from port");
  chk_oe_ddr: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> s.oe_n == !$past(cfg.ddr))
    else $error("enable not from direction");
  cov_force_hidden: cover property (@(posedge clk) disable iff (!rst_n)
    ce && force_go && !cfg.ddr ##1 ce && cfg.ddr);
endmodule : tcm_cou

// >>> logic/tcm_timer.sv
// Purpose: 16-bit timer with normal and clear-on-match modes, two outputs.
// Assumes: AXI4-Lite slave, all inputs synchronous to CLK_SYS.
// Notes: PWM modes and input capture are not built in.
// Function
// - Mode field picks match action and whether pin shows state or port.
// - Reset clears the compare output state.
// - Nonzero mode replaces port value; direction stays with direction bit.
// - Pin shows the value only while direction selects output.
// - State can be set while the pin is not yet driven.
// - Mode field never affects the capture side.
// - Mode zero leaves the state unchanged at matches.
// - New mode acts at next match; force applies the action at once.
// - Counting depends on waveform mode only.
// - Mode 0 counts up without clear and wraps from 0xffff to 0.
// - Overflow flag sets as counter becomes zero; counting never clears it.
// - Taking the overflow interrupt clears the flag.
// - Counter writes are accepted at any time.
// - Clear-on-match clears at compare A (mode 4) or capture top (12).
// - Reaching top sets the flag of the top register.
// - Top is unbuffered; a low top waits for the wrap.
// - Toggle mode flips output A on every match.
// - Prescaler divides by 1, 8, 64, 256, 1024, optionally 16 and 32.
// - In clear-on-match the overflow sets on passing max to zero.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module tcm_timer
  import tcm_pkg::*;
#(
  parameter int EXTRA = 1
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET_N,
  input  wire logic              CE,
  input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic              OVF_INT_ACK,
  output logic                   OUT_A,
  output logic                   OUT_A_OE_N,
  output logic                   OUT_B,
  output logic                   OUT_B_OE_N,
  output logic [3:0]             TIMER_FLAGS
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0]        wgm;
    tcm_com_t          coma;
    tcm_com_t          comb;
    tcm_cs_t           cs;
    logic [15:0]       count;
    logic [15:0]       cmpa;
    logic [15:0]       cmpb;
    logic [15:0]       captop;
    logic [3:0]        flags;
    logic              block;
    logic              frc_a;
    logic              frc_b;
    logic              ddra;
    logic              ddrb;
    logic              porta;
    logic              portb;
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } tcm_state_t;
  tcm_state_t   s;
  tcm_state_t   n;
  logic         tick;
  logic         st_a;
  logic         st_b;
  logic         hit_a;
  logic         hit_b;
  logic         hit_cap;
  logic         ctc_a;
  logic         ctc_cap;
  logic         top_hit;
  logic         non_pwm;
  logic         do_wr;
  logic         wr_cnt;
  logic [3:0]   set_f;
  logic [3:0]   clr_f;
  logic [31:0]  m;
  logic [32:0]  rd;
  tcm_cou_cfg_t cfg_a;
  tcm_cou_cfg_t cfg_b;
  // ==========================================================
  // Register read view, error bit on top
  function automatic logic [32:0] rd_word(input tcm_state_t st, input logic [AXI_AW-1:0] a,
                                          input logic sa, input logic sb);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    case (a)
      OFF_CTRL:   r[31:0] = {21'h00_0000, st.cs, st.comb, st.coma, st.wgm};
      OFF_COUNT:  r[31:0] = {16'h0000, st.count};
      OFF_CMPA:   r[31:0] = {16'h0000, st.cmpa};
      OFF_CMPB:   r[31:0] = {16'h0000, st.cmpb};
      OFF_CAPTOP: r[31:0] = {16'h0000, st.captop};
      OFF_FLAGS:  r[31:0] = {28'h000_0000, st.flags};
      OFF_FORCE:  r[31:0] = 32'h0000_0000;
      OFF_PIN:    r[31:0] = {26'h000_0000, sb, sa, st.portb, st.porta, st.ddrb, st.ddra};
      default:    r[32] = 1'b1;
    endcase
    return r;
  endfunction : rd_word
  // Merges write data into the old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge
  // ==========================================================
  // Submodules
  tcm_presc #(
    .EXTRA (EXTRA)
  ) u_presc (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .ce    (CE),
    .cs    (s.cs),
    .tick  (tick)
  );
  assign cfg_a = '{mode: s.coma, ddr: s.ddra, port: s.porta};
  assign cfg_b = '{mode: s.comb, ddr: s.ddrb, port: s.portb};
  tcm_cou u_cou_a (
    .clk      (CLK_SYS),
    .rst_n    (RESET_N),
    .ce       (CE),
    .cfg      (cfg_a),
    .match    (hit_a),
    .force_go (s.frc_a && non_pwm),
    .pin      (OUT_A),
    .pin_oe_n (OUT_A_OE_N),
    .state    (st_a)
  );
  tcm_cou u_cou_b (
    .clk      (CLK_SYS),
    .rst_n    (RESET_N),
    .ce       (CE),
    .cfg      (cfg_b),
    .match    (hit_b),
    .force_go (s.frc_b && non_pwm),
    .pin      (OUT_B),
    .pin_oe_n (OUT_B_OE_N),
    .state    (st_b)
  );
  // ==========================================================
  // Next state
  always_comb begin
    n = s;
    set_f = 4'h0;
    clr_f = 4'h0;
    wr_cnt = 1'b0;
    n.frc_a = 1'b0;
    n.frc_b = 1'b0;
    // A counter write blocks the match of the next tick.
    hit_a = tick && !s.block && (s.count == s.cmpa);
    hit_b = tick && !s.block && (s.count == s.cmpb);
    hit_cap = tick && !s.block && (s.count == s.captop);
    ctc_a = (s.wgm == WGM_CTC_A);
    ctc_cap = (s.wgm == WGM_CTC_CAP);
    non_pwm = (s.wgm == WGM_NORMAL) || ctc_a || ctc_cap;
    top_hit = (ctc_a && hit_a) || (ctc_cap && hit_cap);
    do_wr = s.aw_got && s.w_got && !s.bvalid;
    m = merge(32'(rd_word(s, s.awaddr, st_a, st_b)), s.wdata, s.wstrb);
    rd = rd_word(s, S_AXI_ARADDR, st_a, st_b);
    // Counter. Other waveform codes count as normal mode.
    if (tick) begin
      n.block = 1'b0;
      n.count = top_hit ? CNT_ZERO : s.count + 16'h0001;
      if (s.count == CNT_MAX) begin
        set_f[FLG_OVF] = 1'b1;
      end
      set_f[FLG_CMPA] = hit_a;
      set_f[FLG_CMPB] = hit_b;
      // The capture flag only marks top here; the mode field plays no part.
      set_f[FLG_CAP] = ctc_cap && hit_cap;
    end
    // Write channel.
    if (s.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (S_AXI_AWVALID && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (s.awaddr)
        OFF_CTRL: begin
          n.wgm = m[CTRL_WGM_LSB +: 4];
          n.coma = tcm_com_t'(m[CTRL_COMA_LSB +: 2]);
          n.comb = tcm_com_t'(m[CTRL_COMB_LSB +: 2]);
          n.cs = tcm_cs_t'(m[CTRL_CS_LSB +: 3]);
        end
        OFF_COUNT: begin
          n.count = m[15:0];
          n.block = 1'b1;
          wr_cnt = 1'b1;
        end
        OFF_CMPA:   n.cmpa = m[15:0];
        OFF_CMPB:   n.cmpb = m[15:0];
        OFF_CAPTOP: n.captop = m[15:0];
        OFF_FLAGS:  clr_f = s.wdata[3:0] & {4{s.wstrb[0]}};
        OFF_FORCE: begin
          n.frc_a = s.wdata[FRC_A] && s.wstrb[0];
          n.frc_b = s.wdata[FRC_B] && s.wstrb[0];
        end
        OFF_PIN: begin
          n.ddra = m[PIN_DDRA];
          n.ddrb = m[PIN_DDRB];
          n.porta = m[PIN_PORTA];
          n.portb = m[PIN_PORTB];
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (OVF_INT_ACK) begin
      clr_f[FLG_OVF] = 1'b1;
    end
    // A flag event in the clearing cycle survives.
    n.flags = (s.flags & ~clr_f) | set_f;
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // Read channel.
    if (s.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && s.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd[31:0];
      n.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
    end
    n.arready = !n.rvalid;
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      s <= '0;
    end else if (CE) begin
      s <= n;
    end
  end
  // ==========================================================
  // Outputs
  assign S_AXI_AWREADY = s.awready;
  assign S_AXI_WREADY = s.wready;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = s.arready;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;
  assign TIMER_FLAGS = s.flags;
  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  chk_normal_wrap: assert property (CE && tick && s.wgm == WGM_NORMAL && s.count == CNT_MAX && !wr_cnt
    |=> s.count == 16'h0000 && s.flags[FLG_OVF])
    else $error("normal mode wrap wrong");
  chk_normal_incr: assert property (CE && tick && s.wgm == WGM_NORMAL && !wr_cnt
    |=> s.count == $past(s.count) + 16'h0001)
    else $error("normal mode did not increment");
  chk_ovf_sticky: assert property (CE && s.flags[FLG_OVF] && !clr_f[FLG_OVF]
    |=> s.flags[FLG_OVF])
    else $error("overflow flag lost");
  chk_ovf_set_wins: assert property (CE && set_f[FLG_OVF] |=> s.flags[FLG_OVF])
    else $error("overflow event lost");
  chk_ovf_ack: assert property (CE && OVF_INT_ACK && !set_f[FLG_OVF] |=> !s.flags[FLG_OVF])
    else $error("overflow not cleared by ack");
  chk_ctc_a_clear: assert property (CE && ctc_a && hit_a && !wr_cnt
    |=> s.count == 16'h0000 && s.flags[FLG_CMPA])
    else $error("clear on compare A wrong");
  chk_ctc_cap_clear: assert property (CE && ctc_cap && hit_cap && !wr_cnt
    |=> s.count == 16'h0000 && s.flags[FLG_CAP])
    else $error("clear on capture top wrong");
  chk_top_unbuf: assert property (CE && tick && ctc_a && s.count > s.cmpa && !wr_cnt
    |=> s.count == $past(s.count) + 16'h0001)
    else $error("counter skipped past low top");
  chk_cnt_write: assert property (CE && wr_cnt |=> s.count == $past(m[15:0]) && s.block)
    else $error("counter write lost");
  chk_b_hold: assert property (s.bvalid && !S_AXI_BREADY |=> s.bvalid)
    else $error("write response dropped");
  cov_normal_ovf: cover property (CE && s.wgm == WGM_NORMAL && set_f[FLG_OVF]);
  cov_ctc_toggle: cover property (CE && ctc_a && hit_a && s.coma == COM_TOGGLE);
  cov_ctc_cap: cover property (CE && ctc_cap && hit_cap);
  cov_force: cover property (CE && s.frc_a && non_pwm);
endmodule : tcm_timer

// >>> tb/tcm_pin_load.sv
// Purpose: Load on a compare output pin.
// Assumes: Enable is low while the block drives the pin.
// Notes: A released pin falls to the pull-down level.
`timescale 1ns/100ps
module tcm_pin_load (
  input  wire logic pin,
  input  wire logic pin_oe_n,
  output logic      level
);
  assign level = pin_oe_n ? 1'b0 : pin;
endmodule : tcm_pin_load

// >>> tb/tb.sv
// Purpose: Self-checking bench of the timer compare block.
// Assumes: CE held high, full-word writes.
// Notes: Bus results are queued by the drivers and checked by a monitor.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb;
  import tcm_pkg::*;
  logic        clk_sys, reset_n, ovf_ack, lvl_a, lvl_b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, we;
  logic        out_a, oe_a_n, out_b, oe_b_n;
  logic [3:0]  flags;
  logic [65:0] re;
  logic [1:0]  wq[$];
  logic [65:0] rq[$];
  int          n_mismatch, comparisons, cycles, g;
  logic [31:0] lfsr = 32'h3b83d915;
  int          fac[7] = '{1, 8, 16, 32, 64, 256, 1024};
  logic [2:0]  cs[7] = '{3'h1, 3'h2, 3'h6, 3'h7, 3'h3, 3'h4, 3'h5};
  logic [1:0]  md[5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  logic        st[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  tcm_timer u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CE(1'b1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .OVF_INT_ACK(ovf_ack), .OUT_A(out_a), .OUT_A_OE_N(oe_a_n), .OUT_B(out_b),
    .OUT_B_OE_N(oe_b_n), .TIMER_FLAGS(flags));
  tcm_pin_load u_load_a (.pin(out_a), .pin_oe_n(oe_a_n), .level(lvl_a));
  tcm_pin_load u_load_b (.pin(out_b), .pin_oe_n(oe_b_n), .level(lvl_b));

  // ==========================================================
  // Clock, timeout and verdict
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ==========================================================
  // Bus tasks and monitor
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    wq.push_back(r);
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back({m, r, d});
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
  endtask : rd

  // Returns the cycles until the A output next changes level.
  task automatic gap(output int n);
    logic p;
    p = out_a;
    n = 0;
    while (out_a === p && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : gap

  always @(posedge clk_sys) begin
    if (bvalid && bready) begin
      we = wq.pop_front();
      `CHK("bresp", we, bresp)
    end
    if (rvalid && rready) begin
      re = rq.pop_front();
      `CHK("rdata", re[31:0], rdata & re[65:34])
      `CHK("rresp", re[33:32], rresp)
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {reset_n, ovf_ack, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, cycles, n_mismatch, comparisons} = '0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(OFF_PIN, 32'h0, 32'hffffffff);
    rd(OFF_CTRL, 32'h0, 32'hffffffff);
    `CHK("oe_a", 1'b1, oe_a_n)
    rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    // State is set by force while the pin is still released.
    wr(OFF_PIN, 32'h4);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_CTRL, {24'h0, md[i], md[i], 4'h0});
      wr(OFF_FORCE, 32'h3);
      repeat (3) @(posedge clk_sys);
      rd(OFF_PIN, {26'h0, st[i], st[i], 4'h4}, 32'h3f);
      `CHK("lvl_a", 1'b0, lvl_a)
      `CHK("lvl_b", 1'b0, lvl_b)
    end
    wr(OFF_PIN, 32'h3);
    repeat (3) @(posedge clk_sys);
    `CHK("lvl_a", 1'b1, lvl_a)
    `CHK("lvl_b", 1'b1, lvl_b)
    wr(OFF_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK("lvl_a", 1'b0, lvl_a)
    `CHK("lvl_b", 1'b0, lvl_b)
    // Counter writes and normal-mode overflow.
    lfsr = nxt(lfsr);
    wr(OFF_COUNT, lfsr);
    rd(OFF_COUNT, {16'h0, lfsr[15:0]}, 32'hffffffff);
    wr(OFF_FLAGS, 32'hf);
    wr(OFF_COUNT, 32'hfff0);
    wr(OFF_CTRL, 32'h100);
    repeat (40) @(posedge clk_sys);
    `CHK("ovf", 1'b1, flags[FLG_OVF])
    @(posedge clk_sys) ovf_ack <= 1'b1;
    @(posedge clk_sys) ovf_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("ovf", 1'b0, flags[FLG_OVF])
    // A top below the count is missed until the wrap.
    wr(OFF_CTRL, 32'h0);
    wr(OFF_COUNT, 32'h100);
    wr(OFF_CMPA, 32'h5);
    wr(OFF_FLAGS, 32'hf);
    wr(OFF_CTRL, 32'h104);
    rd(OFF_COUNT, 32'h0, 32'h0);
    `CHK("above_top", 1'b1, rv[15:0] > 16'h0100)
    `CHK("cmpa_flag", 1'b0, flags[FLG_CMPA])
    wr(OFF_COUNT, 32'h3);
    repeat (20) @(posedge clk_sys);
    `CHK("cmpa_flag", 1'b1, flags[FLG_CMPA])
    rd(OFF_COUNT, 32'h0, 32'h0);
    `CHK("ctc_a", 1'b1, rv[15:0] <= 16'h0005)
    wr(OFF_CAPTOP, 32'h7);
    wr(OFF_CTRL, 32'h10c);
    repeat (20) @(posedge clk_sys);
    `CHK("cap_flag", 1'b1, flags[FLG_CAP])
    rd(OFF_COUNT, 32'h0, 32'h0);
    `CHK("ctc_cap", 1'b1, rv[15:0] <= 16'h0007)
    // Toggle period for every prescaler choice and a random top.
    for (int i = 0; i < 7; i++) begin
      lfsr = nxt(lfsr);
      wr(OFF_CTRL, 32'h0);
      // The first tick after a count write is blocked, so start from the wrap to reach a zero top.
      wr(OFF_COUNT, 32'hffff);
      wr(OFF_CMPA, {30'h0, lfsr[1:0]});
      wr(OFF_CTRL, {21'h0, cs[i], 8'h14});
      // Let the pin switch from port to state before the first level is taken.
      @(posedge clk_sys);
      gap(g);
      gap(g);
      `CHK("half_period", fac[i] * (1 + lfsr[1:0]), g)
    end
    give_verdict();
  end
endmodule : tb
